// ---- verilog/dram_pkg.sv ----
package dram_pkg;
   localparam int ADDR_W = 15;
   localparam int BANK_W = 3;
   localparam int BANKS = 8;
   localparam int DQ_W = 8;
   localparam int COL_W = 10;
   localparam int MR_COUNT = 4;
   localparam int FIFO_DEPTH = 8;
   localparam logic [3:0] BURST_LEN = 4'h8;
   localparam logic [3:0] CHOP_LEN = 4'h4;

   // Address bit roles
   localparam int AP_BIT = 10;
   localparam int BC_BIT = 12;

   // Mode register fields
   localparam int MR_BL_LSB = 0;
   localparam logic [1:0] BL_FIXED8 = 2'h0;
   localparam logic [1:0] BL_OTF = 2'h1;
   localparam logic [1:0] BL_FIXED4 = 2'h2;
   localparam int MR1_TDQS_BIT = 11;
   localparam int MR1_RTT0_BIT = 2;
   localparam int MR1_RTT1_BIT = 6;
   localparam int MR1_RTT2_BIT = 9;

   // Pin command codes {select_n, row_n, col_n, write_n}
   localparam logic [3:0] PIN_MRS = 4'h0;
   localparam logic [3:0] PIN_REF = 4'h1;
   localparam logic [3:0] PIN_PRE = 4'h2;
   localparam logic [3:0] PIN_ACT = 4'h3;
   localparam logic [3:0] PIN_WR = 4'h4;
   localparam logic [3:0] PIN_RD = 4'h5;
   localparam logic [3:0] PIN_ZQ = 4'h6;

   // Reset values
   localparam logic [ADDR_W-1:0] MR_RESET = 15'h0000;
   localparam logic [DQ_W-1:0] DQ_RESET = 8'h00;

   typedef enum logic [3:0] {
      CMD_DESEL, CMD_NOP, CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR, CMD_RD, CMD_ZQ
   } cmd_type;

   typedef enum logic [1:0] {PWR_ON, PWR_PD_PRE, PWR_PD_ACT, PWR_SELF} pwr_type;
endpackage

// ---- verilog/dram_pins.sv ----
`timescale 1ns/1ns

module fifo_buf #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wr_r;
   logic [AW:0] rd_r;
   logic full;
   logic empty;

   assign empty = wr_r == rd_r;
   assign full = (wr_r[AW-1:0] == rd_r[AW-1:0]) && (wr_r[AW] != rd_r[AW]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem_r[rd_r[AW-1:0]];

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_r <= '0;
      end else if (in_valid && !full) begin
         wr_r <= wr_r + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_r <= '0;
      end else if (out_ready && !empty) begin
         rd_r <= rd_r + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (in_valid && !full) begin
         mem_r[wr_r[AW-1:0]] <= in_data;
      end
   end
endmodule

module dram_pins #(
   parameter int READ_LAT = 5,
   parameter int ROW_KEEP = 2
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic ck,
   input wire logic ck_n,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [2:0] ba,
   input wire logic [14:0] addr,
   input wire logic odt,
   input wire logic reset_n,
   input wire logic dm_tdqs,
   input wire logic [7:0] dq_in,
   output logic [7:0] dq_out,
   output logic dq_oe_n,
   input wire logic dqs_in,
   output logic dqs_out,
   output logic dqs_n_out,
   output logic dqs_oe_n,
   output logic term_on,
   output logic tdqs_term_on,
   output logic [1:0] pwr_state,
   output logic [7:0] bank_open
);
   localparam int MEM_AW = dram_pkg::BANK_W + ROW_KEEP + dram_pkg::COL_W;
   localparam int PIN_W = 37;
   localparam logic [3:0] RL_CNT = 4'(READ_LAT);

   logic [PIN_W-1:0] pin_m_r;
   logic [PIN_W-1:0] pin_s_r;
   logic ck_s, ckn_s, cke_s, odt_s, rst_n_s, dm_s, dqs_s;
   logic [3:0] cmd_s;
   logic [2:0] ba_s;
   logic [14:0] addr_s;
   logic [7:0] dq_s;
   logic [1:0] mr_sel;

   logic ck_q_r, dqs_q_r, ck_ok_r;
   logic ck_rise, ck_fall, ck_edge, ck_live, cmd_go, dev_rst;
   dram_pkg::cmd_type dec;
   dram_pkg::pwr_type pwr_r;
   logic [14:0] mr_r [dram_pkg::MR_COUNT];
   logic [7:0] open_r;
   logic [14:0] row_r [dram_pkg::BANKS];
   logic chop, tdqs_en, odt_en;
   logic [3:0] len_now;

   logic [2:0] acc_bank_r;
   logic [14:0] acc_row_r;
   logic [9:0] acc_col_r;
   logic [7:0] mem_r [2**MEM_AW];

   logic [3:0] fetch_cnt_r;
   logic [2:0] fetch_beat_r;
   logic f_in_ready, f_out_valid, push, emit, start;
   logic [7:0] f_out_data;
   logic [3:0] rd_wait_r, out_cnt_r;
   logic rd_go_r;

   logic wr_arm_r, wr_on_r, wr_take, wr_store, dqs_rise, dqs_edge;
   logic [3:0] wr_cnt_r;
   logic [2:0] wr_beat_r;
   logic [MEM_AW-1:0] wr_idx;
   logic odt_q_r;

   function automatic logic [MEM_AW-1:0] mem_index(input logic [2:0] bank, input logic [14:0] row,
                                                   input logic [9:0] col, input logic [2:0] beat);
      logic [2:0] low;
      low = col[2:0] + beat;
      return {bank, row[ROW_KEEP-1:0], col[9:3], low};
   endfunction

   function automatic dram_pkg::cmd_type cmd_decode(input logic [3:0] c);
      dram_pkg::cmd_type t;
      t = dram_pkg::CMD_NOP;
      if (c[3]) t = dram_pkg::CMD_DESEL;
      else if (c == dram_pkg::PIN_MRS) t = dram_pkg::CMD_MRS;
      else if (c == dram_pkg::PIN_REF) t = dram_pkg::CMD_REF;
      else if (c == dram_pkg::PIN_PRE) t = dram_pkg::CMD_PRE;
      else if (c == dram_pkg::PIN_ACT) t = dram_pkg::CMD_ACT;
      else if (c == dram_pkg::PIN_WR) t = dram_pkg::CMD_WR;
      else if (c == dram_pkg::PIN_RD) t = dram_pkg::CMD_RD;
      else if (c == dram_pkg::PIN_ZQ) t = dram_pkg::CMD_ZQ;
      return t;
   endfunction

   // All pins cross together so a command and its address stay aligned
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pin_m_r <= '0;
         pin_s_r <= '0;
      end else begin
         pin_m_r <= {ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, reset_n, dm_tdqs, dqs_in, dq_in};
         pin_s_r <= pin_m_r;
      end
   end

   assign {ck_s, ckn_s, cke_s, cmd_s, ba_s, addr_s, odt_s, rst_n_s, dm_s, dqs_s, dq_s} = pin_s_r;
   assign mr_sel = ba_s[1:0];
   assign dev_rst = sys_rst || !rst_n_s;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ck_q_r <= 1'b0;
         dqs_q_r <= 1'b0;
      end else begin
         ck_q_r <= ck_s;
         dqs_q_r <= dqs_s;
      end
   end

   // No edge until the previous sample is real; a high clock at reset exit is no rise
   always_ff @(posedge ref_clk) begin
      if (dev_rst) begin
         ck_ok_r <= 1'b0;
      end else begin
         ck_ok_r <= 1'b1;
      end
   end

   assign ck_rise = ck_ok_r && ck_s && !ck_q_r && !ckn_s;
   assign ck_fall = ck_ok_r && !ck_s && ck_q_r;
   assign ck_edge = ck_rise || ck_fall;
   assign ck_live = ck_rise && (pwr_r != dram_pkg::PWR_SELF);
   assign cmd_go = ck_live && (pwr_r == dram_pkg::PWR_ON) && cke_s;
   assign dec = cmd_decode(cmd_s);
   assign chop = (mr_r[0][1:0] == dram_pkg::BL_OTF) ? !addr_s[dram_pkg::BC_BIT]
               : (mr_r[0][1:0] == dram_pkg::BL_FIXED4);
   assign len_now = chop ? dram_pkg::CHOP_LEN : dram_pkg::BURST_LEN;
   assign tdqs_en = mr_r[1][dram_pkg::MR1_TDQS_BIT];
   assign odt_en = mr_r[1][dram_pkg::MR1_RTT0_BIT] || mr_r[1][dram_pkg::MR1_RTT1_BIT]
                || mr_r[1][dram_pkg::MR1_RTT2_BIT];
   assign pwr_state = pwr_r;
   assign bank_open = open_r;

   always_ff @(posedge ref_clk) begin
      if (dev_rst) begin
         mr_r <= '{default: dram_pkg::MR_RESET};
      end else if (cmd_go && dec == dram_pkg::CMD_MRS && !ba_s[2]) begin
         mr_r[mr_sel] <= addr_s;
      end
   end

   // Auto-precharge closes the bank at the command; the burst keeps its own row copy
   always_ff @(posedge ref_clk) begin
      if (dev_rst) begin
         open_r <= '0;
      end else if (cmd_go) begin
         if (dec == dram_pkg::CMD_ACT) begin
            open_r[ba_s] <= 1'b1;
         end else if (dec == dram_pkg::CMD_PRE) begin
            if (addr_s[dram_pkg::AP_BIT]) begin
               open_r <= '0;
            end else begin
               open_r[ba_s] <= 1'b0;
            end
         end else if ((dec == dram_pkg::CMD_RD || dec == dram_pkg::CMD_WR) && addr_s[dram_pkg::AP_BIT]) begin
            open_r[ba_s] <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (cmd_go && dec == dram_pkg::CMD_ACT) begin
         row_r[ba_s] <= addr_s;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (cmd_go && (dec == dram_pkg::CMD_RD || dec == dram_pkg::CMD_WR)) begin
         acc_bank_r <= ba_s;
         acc_row_r <= row_r[ba_s];
         acc_col_r <= addr_s[dram_pkg::COL_W-1:0];
      end
   end

   // Power states; self-refresh exit needs no link clock edge
   always_ff @(posedge ref_clk) begin
      if (dev_rst) begin
         pwr_r <= dram_pkg::PWR_ON;
      end else begin
         unique case (pwr_r)
            dram_pkg::PWR_ON: begin
               if (ck_live && !cke_s) begin
                  if (dec == dram_pkg::CMD_REF && open_r == '0) begin
                     pwr_r <= dram_pkg::PWR_SELF;
                  end else if (|open_r) begin
                     pwr_r <= dram_pkg::PWR_PD_ACT;
                  end else begin
                     pwr_r <= dram_pkg::PWR_PD_PRE;
                  end
               end
            end
            dram_pkg::PWR_PD_PRE, dram_pkg::PWR_PD_ACT: begin
               if (ck_live && cke_s) begin
                  pwr_r <= dram_pkg::PWR_ON;
               end
            end
            dram_pkg::PWR_SELF: begin
               if (cke_s) begin
                  pwr_r <= dram_pkg::PWR_ON;
               end
            end
         endcase
      end
   end

   // Read fetch fills the FIFO and stalls when it is full
   assign push = (fetch_cnt_r != 4'h0) && f_in_ready;

   always_ff @(posedge ref_clk) begin
      if (dev_rst) begin
         fetch_cnt_r <= 4'h0;
         fetch_beat_r <= 3'h0;
      end else if (cmd_go && dec == dram_pkg::CMD_RD) begin
         fetch_cnt_r <= len_now;
         fetch_beat_r <= 3'h0;
      end else if (push) begin
         fetch_cnt_r <= fetch_cnt_r - 4'h1;
         fetch_beat_r <= fetch_beat_r + 3'h1;
      end
   end

   fifo_buf #(.WIDTH(dram_pkg::DQ_W), .DEPTH(dram_pkg::FIFO_DEPTH)) rd_fifo (
      .clk(ref_clk),
      .rst(dev_rst),
      .in_valid(fetch_cnt_r != 4'h0),
      .in_ready(f_in_ready),
      .in_data(mem_r[mem_index(acc_bank_r, acc_row_r, acc_col_r, fetch_beat_r)]),
      .out_valid(f_out_valid),
      .out_ready(emit),
      .out_data(f_out_data)
   );

   assign start = ck_rise && rd_wait_r == 4'h1;
   assign emit = ck_edge && (rd_go_r || start) && out_cnt_r != 4'h0 && f_out_valid;

   // One overlapping read restarts the burst; back-to-back reads are not merged
   always_ff @(posedge ref_clk) begin
      if (dev_rst) begin
         rd_wait_r <= 4'h0;
         out_cnt_r <= 4'h0;
         rd_go_r <= 1'b0;
         dq_out <= dram_pkg::DQ_RESET;
         dq_oe_n <= 1'b1;
         dqs_out <= 1'b0;
         dqs_n_out <= 1'b1;
         dqs_oe_n <= 1'b1;
      end else begin
         if (ck_rise && rd_wait_r != 4'h0) begin
            rd_wait_r <= rd_wait_r - 4'h1;
         end
         if (ck_rise && rd_wait_r == 4'h2) begin
            dqs_oe_n <= 1'b0;
            dqs_out <= 1'b0;
            dqs_n_out <= 1'b1;
         end
         if (emit) begin
            dq_out <= f_out_data;
            dq_oe_n <= 1'b0;
            dqs_out <= ck_rise;
            dqs_n_out <= !ck_rise;
            dqs_oe_n <= 1'b0;
            out_cnt_r <= out_cnt_r - 4'h1;
            rd_go_r <= 1'b1;
         end else if (ck_edge && rd_go_r && out_cnt_r == 4'h0) begin
            dq_oe_n <= 1'b1;
            dqs_oe_n <= 1'b1;
            rd_go_r <= 1'b0;
         end
         if (cmd_go && dec == dram_pkg::CMD_RD) begin
            rd_wait_r <= RL_CNT;
            out_cnt_r <= len_now;
         end
      end
   end

   // Write beats arrive on both strobe edges, centred in the data eye
   assign dqs_rise = dqs_s && !dqs_q_r;
   assign dqs_edge = dqs_s ^ dqs_q_r;
   assign wr_take = ((wr_arm_r && dqs_rise) || (wr_on_r && dqs_edge)) && dqs_oe_n
                 && wr_cnt_r != 4'h0;
   assign wr_store = wr_take && !(dm_s && !tdqs_en);
   assign wr_idx = mem_index(acc_bank_r, acc_row_r, acc_col_r, wr_beat_r);

   always_ff @(posedge ref_clk) begin
      if (dev_rst) begin
         wr_arm_r <= 1'b0;
         wr_on_r <= 1'b0;
         wr_cnt_r <= 4'h0;
         wr_beat_r <= 3'h0;
      end else if (cmd_go && dec == dram_pkg::CMD_WR) begin
         wr_arm_r <= 1'b1;
         wr_on_r <= 1'b0;
         wr_cnt_r <= len_now;
         wr_beat_r <= 3'h0;
      end else if (wr_take) begin
         wr_arm_r <= 1'b0;
         wr_on_r <= wr_cnt_r != 4'h1;
         wr_cnt_r <= wr_cnt_r - 4'h1;
         wr_beat_r <= wr_beat_r + 3'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (wr_store) begin
         mem_r[wr_idx] <= dq_s;
      end
   end

   // Termination pin still sampled in power-down, not in self refresh
   always_ff @(posedge ref_clk) begin
      if (dev_rst) begin
         odt_q_r <= 1'b0;
      end else if (ck_live) begin
         odt_q_r <= odt_s;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (dev_rst) begin
         term_on <= 1'b0;
         tdqs_term_on <= 1'b0;
      end else begin
         term_on <= odt_q_r && odt_en && pwr_r != dram_pkg::PWR_SELF && dq_oe_n;
         tdqs_term_on <= odt_q_r && odt_en && pwr_r != dram_pkg::PWR_SELF && tdqs_en;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (dev_rst);

   cs_mask_a: assert property ((ck_live && cmd_s[3]) |=> $stable(open_r))
      else $error("deselected command changed bank state");
   act_open_a: assert property ((cmd_go && dec == dram_pkg::CMD_ACT) |=>
      (open_r[$past(ba_s)] && row_r[$past(ba_s)] == $past(addr_s)))
      else $error("activate did not open row");
   pre_all_a: assert property ((cmd_go && dec == dram_pkg::CMD_PRE && addr_s[10]) |=> open_r == 8'h00)
      else $error("precharge all left a bank open");
   mrs_load_a: assert property ((cmd_go && dec == dram_pkg::CMD_MRS && !ba_s[2]) |=>
      mr_r[$past(mr_sel)] == $past(addr_s))
      else $error("mode register not loaded");
   act_pd_a: assert property ((pwr_r == dram_pkg::PWR_ON && ck_live && !cke_s && |open_r) |=>
      pwr_r == dram_pkg::PWR_PD_ACT)
      else $error("active power-down not entered");
   sr_exit_a: assert property ((pwr_r == dram_pkg::PWR_SELF && cke_s) |=> pwr_r == dram_pkg::PWR_ON)
      else $error("self refresh exit missed");
   odt_off_a: assert property ((!odt_en)[*2] |-> !term_on)
      else $error("termination on while disabled");
   dm_mask_a: assert property ((wr_take && dm_s && !tdqs_en) |=> mem_r[$past(wr_idx)] == $past(mem_r[wr_idx]))
      else $error("masked beat was written");
   dqs_edge_a: assert property (($changed(dqs_out) && !dqs_oe_n && $past(!dqs_oe_n)) |-> $past(ck_edge))
      else $error("read strobe moved without clock edge");
   sr_quiet_a: assert property ((pwr_r == dram_pkg::PWR_SELF) |-> !cmd_go && !term_on)
      else $error("inputs honoured in self refresh");

   rd_burst_c: cover property (emit && out_cnt_r == 4'h1);
   sr_cycle_c: cover property (pwr_r == dram_pkg::PWR_SELF ##1 pwr_r == dram_pkg::PWR_ON);
   wr_masked_c: cover property (wr_take && !wr_store);
endmodule

// ---- tb/ctrl_model.sv ----
`timescale 1ns/1ns

module ctrl_model (
   input wire logic ref_clk,
   output logic ck,
   output logic ck_n,
   output logic cke,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [2:0] ba,
   output logic [14:0] addr,
   output logic odt,
   output logic reset_n,
   output logic dm_tdqs,
   output logic [7:0] dq_in,
   input wire logic [7:0] dq_out,
   input wire logic dq_oe_n,
   output logic dqs_in,
   input wire logic dqs_out,
   input wire logic dqs_oe_n
);
   logic [7:0] dq_drv = 8'h00;
   logic dqs_drv = 1'b0;
   logic last_r = 1'b0;
   logic [7:0] rd_q[$];
   time beat_t[$];
   int strobe_bad = 0;

   initial begin
      cke = 1'b1;
      {cs_n, ras_n, cas_n, we_n} = 4'hf;
      ba = 3'h0;
      addr = 15'h0000;
      odt = 1'b0;
      reset_n = 1'b1;
      dm_tdqs = 1'b0;
   end

   // Free-running pair, phase unrelated to ref_clk
   initial begin
      ck = 1'b0;
      #3;
      forever begin
         ck = 1'b1;
         #62;
         ck = 1'b0;
         #63;
      end
   end
   assign ck_n = ~ck;

   // Shared wires: whoever has its enable low owns the line
   assign dq_in = dq_oe_n ? dq_drv : dq_out;
   assign dqs_in = dqs_oe_n ? dqs_drv : dqs_out;

   // A beat is each strobe swing while the device owns the bus
   always @(posedge ref_clk) begin
      if (!dq_oe_n && dqs_out !== last_r) begin
         rd_q.push_back(dq_out);
         beat_t.push_back($time);
         if (dqs_oe_n !== 1'b0)
            strobe_bad++;
      end
      last_r <= dq_oe_n ? 1'b0 : dqs_out;
   end

   // Pins move mid-cycle, far from the rising crossing
   task automatic cmd(input logic [3:0] code, input logic [2:0] b, input logic [14:0] a, input logic en);
      @(negedge ck);
      @(posedge ref_clk);
      {cs_n, ras_n, cas_n, we_n} <= code;
      ba <= b;
      addr <= a;
      cke <= en;
      @(posedge ck);
      @(negedge ck);
      @(posedge ref_clk);
      cs_n <= 1'b1;
      addr <= ~a;
      @(negedge ref_clk);
   endtask

   // Select pulse that ends before any rising crossing
   task automatic glitch(input logic [2:0] b);
      @(negedge ck);
      @(posedge ref_clk);
      {cs_n, ras_n, cas_n, we_n} <= dram_pkg::PIN_ACT;
      ba <= b;
      repeat (4) @(posedge ref_clk);
      cs_n <= 1'b1;
   endtask

   // Strobe edge sits mid-eye of each beat
   task automatic wr_beats(input logic [63:0] d, input logic [7:0] m, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         dq_drv <= d[8*i +: 8];
         dm_tdqs <= m[i];
         repeat (4) @(posedge ref_clk);
         dqs_drv <= (i % 2 == 0);
         repeat (3) @(posedge ref_clk);
      end
      @(posedge ref_clk);
      dq_drv <= ~dq_drv;
      dqs_drv <= 1'b0;
   endtask

   task automatic set_odt(input logic v);
      @(negedge ck);
      @(posedge ref_clk);
      odt <= v;
      @(posedge ck);
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   // Raised just after a rise so no crossing helps the exit
   task automatic cke_up();
      @(posedge ck);
      @(posedge ref_clk);
      cke <= 1'b1;
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   task automatic set_reset(input logic v);
      @(posedge ref_clk);
      reset_n <= v;
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
endmodule

// ---- tb/dram_pins_test.sv ----
`timescale 1ns/1ns

module dram_pins_test;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, odt, reset_n, dm_tdqs;
   logic dq_oe_n, dqs_in, dqs_out, dqs_n_out, dqs_oe_n, term_on, tdqs_term_on;
   logic [2:0] ba;
   logic [14:0] addr;
   logic [7:0] dq_in, dq_out, bank_open, exp_open;
   logic [1:0] pwr_state;
   logic [7:0] mem[8];
   int err_total = 0;
   int n_checks = 0;

   dram_pins i_dut (.ref_clk, .sys_rst, .ck, .ck_n, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .odt,
      .reset_n, .dm_tdqs, .dq_in, .dq_out, .dq_oe_n, .dqs_in, .dqs_out, .dqs_n_out, .dqs_oe_n, .term_on,
      .tdqs_term_on, .pwr_state, .bank_open);

   ctrl_model i_ctrl (.ref_clk, .ck, .ck_n, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .odt, .reset_n,
      .dm_tdqs, .dq_in, .dq_out, .dq_oe_n, .dqs_in, .dqs_out, .dqs_oe_n);

   initial begin
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic mrs(input logic [2:0] b, input logic [14:0] a);
      i_ctrl.cmd(dram_pkg::PIN_MRS, b, a, 1'b1);
      repeat (8) @(posedge ref_clk);
   endtask

   // Reads always target bank 2; also proves the bus is handed back
   task automatic rd(input logic [14:0] a, input int n);
      int k;
      int span;
      i_ctrl.rd_q.delete();
      i_ctrl.beat_t.delete();
      i_ctrl.cmd(dram_pkg::PIN_RD, 3'h2, a, 1'b1);
      k = 0;
      while (i_ctrl.rd_q.size() < n && k < 600) begin
         @(posedge ref_clk);
         k++;
      end
      repeat (60) @(posedge ref_clk);
      if (k >= 600) begin
         err_total++;
         $display("mismatch at %0t: read burst never came", $time);
         finish_test();
      end
      check(16'(i_ctrl.rd_q.size()), 16'(n), "beat count");
      for (int i = 0; i < n; i++)
         check(i_ctrl.rd_q[i], mem[(a[2:0] + i) % 8], "read beat");
      span = int'(i_ctrl.beat_t[n-1] - i_ctrl.beat_t[0]);
      check(span >= (n - 1) * 60 && span <= (n - 1) * 65, 1'b1, "beat spacing");
      check(16'(i_ctrl.strobe_bad), 16'h0000, "strobe owner");
      check(dq_oe_n, 1'b1, "bus released");
      check({dqs_out, dqs_n_out}, 2'b01, "strobe pair after burst");
   endtask

   // Column 0 of bank 2; a masked beat keeps the old byte
   task automatic wr(input logic [63:0] d, input logic [7:0] m, input logic masking);
      i_ctrl.cmd(dram_pkg::PIN_WR, 3'h2, 15'h0000, 1'b1);
      i_ctrl.wr_beats(d, m, 8);
      for (int i = 0; i < 8; i++)
         if (!(m[i] && masking))
            mem[i] = d[8*i +: 8];
      repeat (20) @(posedge ref_clk);
   endtask

   task automatic t_idle();
      check(bank_open, 8'h00, "banks after reset");
      check(pwr_state, 2'h0, "power after reset");
      check({dq_oe_n, dqs_oe_n, term_on, tdqs_term_on}, 4'hc, "pins after reset");
      $display("test idle done");
   endtask

   task automatic t_banks();
      exp_open = 8'h00;
      for (int b = 0; b < 8; b++) begin
         i_ctrl.cmd(dram_pkg::PIN_ACT, 3'(b), 15'h1234, 1'b1);
         exp_open[b] = 1'b1;
         check(bank_open, exp_open, "open by bank");
      end
      i_ctrl.cmd(dram_pkg::PIN_PRE, 3'h3, 15'h0000, 1'b1);
      check(bank_open, 8'hf7, "single close");
      i_ctrl.cmd(4'hb, 3'h3, 15'h0000, 1'b1);
      check(bank_open, 8'hf7, "deselected act");
      i_ctrl.glitch(3'h3);
      repeat (40) @(posedge ref_clk);
      check(bank_open, 8'hf7, "act between crossings");
      i_ctrl.cmd(dram_pkg::PIN_PRE, 3'h0, 15'h0400, 1'b1);
      check(bank_open, 8'h00, "close all");
      $display("test banks done");
   endtask

   task automatic t_data();
      i_ctrl.cmd(dram_pkg::PIN_ACT, 3'h2, 15'h0005, 1'b1);
      wr(64'h1716151413121110, 8'h00, 1'b1);
      wr(64'ha7a6a5a4a3a2a1a0, 8'h08, 1'b1);
      rd(15'h0002, 8);
      mrs(3'h4, 15'h0001);
      rd(15'h0000, 8);
      mrs(3'h0, 15'h0001);
      rd(15'h0004, 4);
      rd(15'h1004, 8);
      mrs(3'h0, 15'h0002);
      rd(15'h1000, 4);
      mrs(3'h0, 15'h0000);
      rd(15'h0401, 8);
      check(bank_open, 8'h00, "auto precharge");
      $display("test data done");
   endtask

   // Termination-strobe mode turns the mask ball into a load only
   task automatic t_tdqs();
      mrs(3'h1, 15'h0800);
      i_ctrl.cmd(dram_pkg::PIN_ACT, 3'h2, 15'h0005, 1'b1);
      wr(64'h3736353433323130, 8'hff, 1'b0);
      rd(15'h0000, 8);
      mrs(3'h1, 15'h0000);
      i_ctrl.cmd(dram_pkg::PIN_PRE, 3'h0, 15'h0400, 1'b1);
      $display("test tdqs done");
   endtask

   task automatic t_odt();
      i_ctrl.set_odt(1'b1);
      check(term_on, 1'b0, "odt while disabled");
      mrs(3'h1, 15'h0004);
      check(term_on, 1'b1, "odt enabled");
      check(tdqs_term_on, 1'b0, "tdqs load without tdqs mode");
      mrs(3'h1, 15'h0804);
      check(tdqs_term_on, 1'b1, "tdqs load in tdqs mode");
      i_ctrl.set_odt(1'b0);
      check(term_on, 1'b0, "odt dropped");
      check(tdqs_term_on, 1'b0, "tdqs load dropped");
      mrs(3'h1, 15'h0000);
      $display("test odt done");
   endtask

   task automatic t_power();
      i_ctrl.cmd(4'hf, 3'h0, 15'h0000, 1'b0);
      check(pwr_state, 2'h1, "precharge power-down");
      i_ctrl.cmd(dram_pkg::PIN_ACT, 3'h0, 15'h0000, 1'b0);
      check(bank_open, 8'h00, "act in power-down");
      i_ctrl.cmd(4'hf, 3'h0, 15'h0000, 1'b1);
      check(pwr_state, 2'h0, "power-down exit");
      i_ctrl.cmd(dram_pkg::PIN_ACT, 3'h1, 15'h0000, 1'b1);
      i_ctrl.cmd(4'hf, 3'h0, 15'h0000, 1'b0);
      check(pwr_state, 2'h2, "active power-down");
      i_ctrl.cmd(4'hf, 3'h0, 15'h0000, 1'b1);
      i_ctrl.cmd(dram_pkg::PIN_PRE, 3'h1, 15'h0000, 1'b1);
      i_ctrl.cmd(dram_pkg::PIN_REF, 3'h0, 15'h0000, 1'b0);
      check(pwr_state, 2'h3, "self refresh");
      i_ctrl.cke_up();
      check(pwr_state, 2'h0, "exit without crossing");
      $display("test power done");
   endtask

   task automatic t_reset();
      i_ctrl.cmd(dram_pkg::PIN_ACT, 3'h5, 15'h0000, 1'b1);
      check(bank_open, 8'h20, "open before reset");
      i_ctrl.set_reset(1'b0);
      check(bank_open, 8'h00, "pin reset");
      i_ctrl.set_reset(1'b1);
      i_ctrl.cmd(dram_pkg::PIN_ACT, 3'h6, 15'h0000, 1'b1);
      check(bank_open, 8'h40, "after pin reset");
      $display("test reset done");
   endtask

   initial begin
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (10) @(posedge ref_clk);
      t_idle();
      t_banks();
      t_data();
      t_tdqs();
      t_odt();
      t_power();
      t_reset();
      finish_test();
   end
endmodule
